// *** bench/disk_drive_status_and_strap_logic_bench.sv ***
`timescale 1ns/1ps
// ==========================================================
// bench for the drive status and strap block
module disk_drive_status_and_strap_logic_bench
    import drive_pkg::*;
;
    localparam int REVC = 200;
    logic clk, sys_rst, motor_on_n, step_dir_n, step_n, write_gate_n, write_data_n, side_sel_n;
    logic shared_n, index_hole, disk_in, protect_notch, head_at_zero, read_flux;
    logic index_n, track0_n, wprot_n, read_n, ready_o, ready_oe, head_load, spindle_on;
    logic indicator, step_pulse, step_in, write_en, erase_en, write_pulse;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0] drive_sel_n, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, q;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    drive_ctl #(.HEAD_SETTLE(50), .STEP_SETTLE(18), .WG_OFF(10), .HOLE_WAIT(400),
        .READY_MAX(800), .RECAL_MAX(255), .RECAL_STEP(3), .REV(REVC)) uut (
        .clk, .sys_rst, .drive_sel_n, .motor_on_n, .step_dir_n, .step_n, .write_gate_n,
        .write_data_n, .side_sel_n, .shared_n, .index_hole, .disk_in, .protect_notch,
        .head_at_zero, .read_flux, .index_n, .track0_n, .wprot_n, .read_n, .ready_o,
        .ready_oe, .head_load, .spindle_on, .indicator, .step_pulse, .step_in, .write_en,
        .erase_en, .write_pulse, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    media_model #(.REV(REVC)) disk (.clk, .spin(spindle_on), .loaded(disk_in), .hole(index_hole));
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    // ==========================================================
    // shared tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task axi(input logic w, input logic [3:0] a, input logic [31:0] d);
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            s_axi_bready <= 1'h1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            s_axi_rready <= 1'h1;
        end
        do begin
            @(posedge clk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'h1);
        r = w ? s_axi_bresp : s_axi_rresp;
        q = s_axi_rdata;
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        @(posedge clk);
    endtask
    task strap(input logic [31:0] v);
        axi(1'h1, REG_STRAP, v);
        repeat (8) @(posedge clk);
    endtask
    task wait_oe(input logic v);
        n = 0;
        while (ready_oe !== v && n < 3000) begin
            @(posedge clk);
            n++;
        end
    endtask
    task holes(input int len);
        n = 0;
        repeat (len) begin
            @(posedge clk);
            n += (index_n === 1'h0);
        end
    endtask
    task report_and_stop;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task t_regs;
        axi(1'h0, REG_STRAP, 32'h0);
        chk(q, 32'(STRAP_RESET));
        axi(1'h1, REG_STATUS, 32'hFFFF);
        chk(32'(r), 32'(RESP_OKAY));
        axi(1'h0, REG_STATUS, 32'h0);
        chk(32'(q[4:0]), 32'(ST_IDLE));
        axi(1'h0, 4'h8, 32'h0);
        chk(32'(r), 32'(RESP_DECERR));
        $display("registers done");
    endtask
    task t_spin;
        int t0;
        t0 = cyc;
        drive_sel_n <= 4'hE;
        disk_in <= 1'h1;
        motor_on_n <= 1'h0;
        repeat (450) @(posedge clk);
        axi(1'h0, REG_STATUS, 32'h0);
        chk(32'(q[4:0]), 32'(ST_PRE));
        chk(32'(head_load), 32'h1);
        chk(32'(ready_oe), 32'h0);
        wait_oe(1'h1);
        chk(32'(cyc - t0 < 800), 32'h1);
        holes(REVC + 10);
        chk(32'(n > 0), 32'h1);
        drive_sel_n <= 4'hF;
        holes(REVC + 10);
        chk(32'(n), 32'h0);
        drive_sel_n <= 4'hE;
        $display("spin-up done");
    endtask
    task t_open;
        strap(32'h124);
        chk(32'(ready_oe), 32'h0);
        strap(32'h514);
        chk(32'(ready_oe), 32'h0);
        axi(1'h0, REG_STATUS, 32'h0);
        chk(32'(q[8]), 32'h1);
        strap(32'(STRAP_RESET));
        wait_oe(1'h1);
        chk(32'(ready_oe), 32'h1);
        $display("ready terminal done");
    endtask
    task t_prot;
        protect_notch <= 1'h1;
        write_gate_n <= 1'h0;
        side_sel_n <= 1'h0;
        repeat (6) @(posedge clk);
        chk(32'({wprot_n, write_en, erase_en}), 32'h0);
        protect_notch <= 1'h0;
        {write_data_n, head_at_zero} <= 2'h1;
        repeat (6) @(posedge clk);
        chk(32'({wprot_n, write_en, erase_en, write_pulse, track0_n}), 32'h1E);
        {write_gate_n, write_data_n} <= 2'h3;
        $display("protect done");
    endtask
    task t_shared;
        for (int i = 0; i < 4; i++) begin
            strap(32'h110 | 32'(i << 2));
            shared_n <= 1'h1;
            repeat (6) @(posedge clk);
            chk(32'(head_load), 32'(i[1] == 1'h0));
            drive_sel_n <= 4'hF;
            shared_n <= 1'h0;
            repeat (6) @(posedge clk);
            chk(32'(indicator), 32'(i[0]));
            drive_sel_n <= 4'hE;
        end
        shared_n <= 1'h1;
        strap(32'(STRAP_RESET));
        $display("shared pin done");
    endtask
    task t_motor;
        motor_on_n <= 1'h1;
        wait_oe(1'h0);
        chk(32'(n < 3000), 32'h1);
        repeat (8) @(posedge clk);
        chk(32'(spindle_on), 32'h0);
        strap(32'h054);
        repeat (400) @(posedge clk);
        chk(32'(spindle_on), 32'h1);
        holes(2 * REVC);
        chk(32'(n), 32'h0);
        strap(32'h154);
        holes(REVC + 10);
        chk(32'(n > 0), 32'h1);
        drive_sel_n <= 4'hF;
        shared_n <= 1'h0;
        repeat (8) @(posedge clk);
        chk(32'(spindle_on), 32'h1);
        shared_n <= 1'h1;
        repeat (8) @(posedge clk);
        chk(32'(spindle_on), 32'h0);
        $display("motor done");
    endtask
    // ==========================================================
    // main sequence and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            report_and_stop;
        end
    end
    initial begin
        sys_rst = 1'h1;
        drive_sel_n = 4'hF;
        {motor_on_n, step_dir_n, step_n, write_gate_n, write_data_n, side_sel_n} = 6'h3F;
        shared_n = 1'h1;
        {disk_in, protect_notch, head_at_zero, read_flux} = 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr} = 8'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        repeat (16) @(posedge clk);
        sys_rst <= 1'h0;
        t_regs;
        t_spin;
        t_open;
        t_prot;
        t_shared;
        t_motor;
        report_and_stop;
    end
endmodule
bind drive_ctl drive_ctl_asserts chk_i (.clk, .sys_rst, .drive_sel_n, .motor_on_n, .index_hole,
    .disk_in, .index_n, .track0_n, .wprot_n, .ready_o, .ready_oe, .spindle_on, .step_pulse,
    .write_en, .erase_en);

// *** bench/drive_ctl_asserts.sv ***
`timescale 1ns/1ps
// ==========================================================
// port checker for the drive block
module drive_ctl_asserts (
    input wire logic clk, // clock
    input wire logic sys_rst, // reset
    input wire logic [3:0] drive_sel_n, // selects
    input wire logic motor_on_n, // motor-on
    input wire logic index_hole, // hole sensor
    input wire logic disk_in, // disk sensor
    input wire logic index_n, // hole out
    input wire logic track0_n, // zero out
    input wire logic wprot_n, // protect out
    input wire logic ready_o, // ready level
    input wire logic ready_oe, // ready drive
    input wire logic spindle_on, // spindle
    input wire logic step_pulse, // step
    input wire logic write_en, // write
    input wire logic erase_en // erase
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // unit address stays 0 in this bench, so select line 0 is ours
    sequence s_unsel;
        drive_sel_n[0] [*5];
    endsequence
    sequence s_motor;
        !motor_on_n [*5];
    endsequence
    property p_low; ready_o == 1'h0; endproperty
    a_low: assert property (p_low) else $error("ready level not low");
    property p_prot; !wprot_n |-> !write_en && !erase_en; endproperty
    a_prot: assert property (p_prot) else $error("write while protected");
    // cycles the ready terminal is still pulled with motor-on false
    int off_cnt;
    always_ff @(posedge clk) off_cnt <= (motor_on_n && ready_oe) ? off_cnt + 1 : 0;
    property p_drop; off_cnt < 3000; endproperty
    a_drop: assert property (p_drop) else $error("ready held after motor off");
    property p_hole; s_unsel |-> index_n; endproperty
    a_hole: assert property (p_hole) else $error("hole pulse while unselected");
    property p_gate; s_unsel |-> track0_n && wprot_n && !write_en; endproperty
    a_gate: assert property (p_gate) else $error("output while unselected");
    property p_step; s_unsel |-> !step_pulse; endproperty
    a_step: assert property (p_step) else $error("step while unselected");
    property p_spin; s_motor |-> spindle_on; endproperty
    a_spin: assert property (p_spin) else $error("spindle off with motor on");
    property p_rdy; ready_oe |-> $past(!motor_on_n, 6) && $past(disk_in, 6); endproperty
    a_rdy: assert property (p_rdy) else $error("ready without motor or disk");
    property p_edge; $fell(index_n) |-> $past(index_hole, 3); endproperty
    a_edge: assert property (p_edge) else $error("hole pulse without hole");
endmodule

// *** bench/media_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// spinning disk: one hole per revolution, exact nominal interval
module media_model #(
    parameter int REV = 200
) (
    input wire logic clk, // clock
    input wire logic spin, // spindle running
    input wire logic loaded, // disk in place
    output logic hole // hole sensor
);
    int cnt;
    // a stopped disk shows no hole, sensor reads low
    always_ff @(posedge clk) begin
        if (!(spin && loaded)) begin
            cnt <= 0;
            hole <= 1'h0;
        end else begin
            cnt <= (cnt == REV - 1) ? 0 : cnt + 1;
            hole <= (cnt >= REV - 4);
        end
    end
endmodule

// *** core/drive_ctl.sv ***
`timescale 1ns/1ps
module drive_ctl
    import drive_pkg::*;
#(
    parameter int HEAD_SETTLE = HEAD_SETTLE_CYC,
    parameter int STEP_SETTLE = STEP_SETTLE_CYC,
    parameter int WG_OFF = WG_OFF_CYC,
    parameter int HOLE_WAIT = HOLE_CYC,
    parameter int READY_MAX = READY_MAX_CYC,
    parameter int RECAL_MAX = RECAL_CYC,
    parameter int RECAL_STEP = RECAL_STEP_CYC,
    parameter int REV = REV_CYC
) (
    input wire logic clk, // 10 MHz clock
    input wire logic sys_rst, // async reset, high
    input wire logic [3:0] drive_sel_n, // drive select lines
    input wire logic motor_on_n, // motor-on command
    input wire logic step_dir_n, // low = step in
    input wire logic step_n, // step pulse
    input wire logic write_gate_n, // write gate
    input wire logic write_data_n, // write data pulses
    input wire logic side_sel_n, // side one select
    input wire logic shared_n, // pin-four busy / head-load
    input wire logic index_hole, // hole sensor, high on hole
    input wire logic disk_in, // disk present sensor
    input wire logic protect_notch, // notch masked sensor
    input wire logic head_at_zero, // track-zero sensor
    input wire logic read_flux, // raw read pulse from channel
    output logic index_n, // index/sector output
    output logic track0_n, // track-zero output
    output logic wprot_n, // write-protect output
    output logic read_n, // read data output
    output logic ready_o, // ready terminal level
    output logic ready_oe, // ready terminal pull-down enable
    output logic head_load, // head load solenoid
    output logic spindle_on, // spindle motor run
    output logic indicator, // front indicator
    output logic step_pulse, // one-cycle step to actuator
    output logic step_in, // step direction, high = in
    output logic write_en, // write driver enable
    output logic erase_en, // erase head enable
    output logic write_pulse, // write data to head
    input wire logic [3:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [3:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready // read data ready
);

    // ==========================================================
    // elaboration checks
    localparam int REV_LO = REV - (REV * REV_TOL_PCT) / 100;
    localparam int REV_HI = REV + (REV * REV_TOL_PCT) / 100;
    localparam int REV_HALF = REV * HALF_SPEED_MUL;

    generate
        if (REV_HALF >= 2 ** CW || READY_MAX >= 2 ** CW || HOLE_WAIT >= 2 ** CW ||
            RECAL_MAX >= 2 ** CW || HEAD_SETTLE >= 2 ** CW || REV < 100 ||
            RECAL_STEP < 1 || STEP_SETTLE < 1 || WG_OFF < 1) begin : g_bad
            $error("drive_ctl: timing parameter out of range");
        end
    endgenerate

    function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] c);
        sat_inc = (c == {CW{1'b1}}) ? c : c + 1'b1;
    endfunction

    // ==========================================================
    // input synchronisers
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] sy1;
    logic [NSYNC-1:0] sy;
    logic [NSYNC-1:0] sy_d;

    assign raw = {read_flux, head_at_zero, protect_notch, disk_in, index_hole, shared_n,
                  side_sel_n, write_data_n, write_gate_n, step_n, step_dir_n, motor_on_n,
                  drive_sel_n};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    sy1[gi] <= SYNC_IDLE[gi];
                    sy[gi] <= SYNC_IDLE[gi];
                    sy_d[gi] <= SYNC_IDLE[gi];
                end else begin
                    sy1[gi] <= raw[gi];
                    sy[gi] <= sy1[gi];
                    sy_d[gi] <= sy[gi];
                end
            end
        end
    endgenerate

    // ==========================================================
    // straps and decoded inputs
    logic [STRAP_W-1:0] strap;
    drive_state_t state;
    drive_state_t next_state;
    logic [CW-1:0] hl_cnt;
    logic [CW-1:0] step_cnt;
    logic [CW-1:0] wg_cnt;
    logic [CW-1:0] side_cnt;
    logic [CW-1:0] spin_cnt;
    logic [CW-1:0] idx_cnt;
    logic [CW-1:0] rc_cnt;
    logic [CW-1:0] rs_cnt;
    logic recal_pend;
    logic recal_fail;
    logic spinup_late;

    wire [1:0] addr_strap = strap[SB_ADDR +: 2];
    wire selected = ~sy[SI_SEL + addr_strap];
    wire motor_cmd = ~sy[SI_MOTOR];
    wire dir_in = ~sy[SI_DIR];
    wire wgate = ~sy[SI_WGATE];
    wire wdata = ~sy[SI_WDATA];
    wire pin4 = ~sy[SI_SHARED];
    wire disk = sy[SI_DISK];
    wire protect = sy[SI_PROT];
    wire at_zero = sy[SI_ZERO];
    wire flux = sy[SI_FLUX];
    wire step_edge = sy[SI_STEP] & ~sy_d[SI_STEP]; // trailing edge of step pulse
    wire index_edge = sy[SI_INDEX] & ~sy_d[SI_INDEX];
    wire side_edge = sy[SI_SIDE] ^ sy_d[SI_SIDE];

    // pin four is shared out by the two function straps
    wire busy = strap[SB_BUSY] & pin4;
    wire load_req = strap[SB_LOAD] ? (pin4 & selected) : selected;
    wire is_ready = (state == ST_READY);
    wire is_pre = (state == ST_PRE);
    wire in_recal = (state == ST_RECAL);
    wire next_head = (is_ready | is_pre) & load_req;
    wire next_ind = selected | busy;
    wire next_spin = motor_cmd | (strap[SB_MOTOR] & next_ind);
    wire wg_eff = selected & wgate & ~protect;

    // step refused while writing, at track zero going out, or recalibrating
    wire host_step = step_edge & selected & ~wg_eff & ~(at_zero & ~dir_in) & ~in_recal;
    wire recal_step = in_recal & ~at_zero & (rs_cnt >= CW'(RECAL_STEP));
    wire recal_done = in_recal & (at_zero | rc_cnt >= CW'(RECAL_MAX));

    // ==========================================================
    // spindle speed qualification
    wire half_ok = idx_cnt < CW'(REV_HALF);
    wire tol_ok = (idx_cnt >= CW'(REV_LO)) & (idx_cnt <= CW'(REV_HI));
    wire idx_lost = idx_cnt >= CW'(REV_HALF);
    wire spin_ok = spindle_on & disk;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (recal_pend & strap[SB_RECAL]) begin
                    next_state = ST_RECAL;
                end else if (spin_ok) begin
                    next_state = ST_SPIN;
                end
            end
            ST_SPIN: begin
                if (!spin_ok) begin
                    next_state = ST_IDLE;
                end else if (index_edge & half_ok) begin
                    next_state = ST_PRE;
                end
            end
            ST_PRE: begin
                if (!spin_ok) begin
                    next_state = ST_IDLE;
                end else if (idx_lost | (index_edge & ~half_ok)) begin
                    next_state = ST_SPIN;
                end else if (index_edge & tol_ok & motor_cmd) begin
                    next_state = ST_READY;
                end
            end
            ST_READY: begin
                if (!spin_ok) begin
                    next_state = ST_IDLE;
                end else if (!motor_cmd | idx_lost | (index_edge & ~tol_ok)) begin
                    next_state = ST_PRE;
                end
            end
            ST_RECAL: begin
                if (recal_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            recal_pend <= 1'b1;
        end else begin
            state <= next_state;
            recal_pend <= 1'b0;
        end
    end

    // ==========================================================
    // elapsed-time counters, saturating
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hl_cnt <= '0;
            step_cnt <= {CW{1'b1}};
            wg_cnt <= {CW{1'b1}};
            side_cnt <= {CW{1'b1}};
        end else begin
            hl_cnt <= head_load ? sat_inc(hl_cnt) : '0;
            step_cnt <= (host_step | recal_step) ? '0 : sat_inc(step_cnt);
            wg_cnt <= wg_eff ? '0 : sat_inc(wg_cnt);
            side_cnt <= side_edge ? '0 : sat_inc(side_cnt);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            spin_cnt <= '0;
            idx_cnt <= {CW{1'b1}};
            rc_cnt <= '0;
            rs_cnt <= '0;
        end else begin
            spin_cnt <= spin_ok ? sat_inc(spin_cnt) : '0;
            idx_cnt <= index_edge ? '0 : sat_inc(idx_cnt);
            rc_cnt <= in_recal ? sat_inc(rc_cnt) : '0;
            rs_cnt <= (!in_recal | recal_step) ? '0 : sat_inc(rs_cnt);
        end
    end

    // status flags: spinup_late cleared by spin_ok going away, recal_fail only by reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            recal_fail <= 1'b0;
            spinup_late <= 1'b0;
        end else begin
            if (recal_done & ~at_zero) begin
                recal_fail <= 1'b1;
            end
            if (!spin_ok) begin
                spinup_late <= 1'b0;
            end else if (!is_ready & motor_cmd & spin_cnt >= CW'(READY_MAX)) begin
                spinup_late <= 1'b1;
            end
        end
    end

    // ==========================================================
    // output gating
    wire settled = hl_cnt >= CW'(HEAD_SETTLE);
    wire hole_ok = spin_cnt >= CW'(HOLE_WAIT);
    wire read_quiet = settled & (step_cnt >= CW'(STEP_SETTLE)) &
                      (wg_cnt >= CW'(WG_OFF)) & (side_cnt >= CW'(SIDE_CYC));
    wire read_valid = is_ready & read_quiet;
    wire idx_gate = selected & (strap[SB_IDXG] | is_ready);
    wire rd_gate = selected & (~strap[SB_RDG] | is_ready) & read_quiet;
    // hard-sectored media cannot qualify ready, so the terminal stays released
    wire rdy_drive = strap[SB_READY] & ~strap[SB_HARD] & selected & is_ready;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            index_n <= 1'b1;
            track0_n <= 1'b1;
            wprot_n <= 1'b1;
            read_n <= 1'b1;
            ready_o <= 1'b0;
            ready_oe <= 1'b0;
        end else begin
            index_n <= ~(idx_gate & sy[SI_INDEX]);
            track0_n <= ~(selected & at_zero);
            wprot_n <= ~(selected & protect);
            read_n <= ~(rd_gate & flux);
            ready_o <= 1'b0;
            ready_oe <= rdy_drive;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            head_load <= 1'b0;
            spindle_on <= 1'b0;
            indicator <= 1'b0;
            step_pulse <= 1'b0;
            step_in <= 1'b0;
            write_en <= 1'b0;
            erase_en <= 1'b0;
            write_pulse <= 1'b0;
        end else begin
            head_load <= next_head;
            spindle_on <= next_spin;
            indicator <= next_ind;
            step_pulse <= host_step | recal_step;
            step_in <= in_recal ? 1'b0 : dir_in;
            write_en <= wg_eff;
            erase_en <= wg_eff;
            write_pulse <= wg_eff & wdata;
        end
    end

    // ==========================================================
    // register slave
    wire ar_map = (s_axi_araddr == REG_STRAP) | (s_axi_araddr == REG_STATUS);
    wire wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire [31:0] strap_word = {21'h000000, strap};
    wire [31:0] status_word = {17'h00000, at_zero, write_en, spindle_on, selected,
                               recal_fail, spinup_late, hole_ok, settled, head_load,
                               read_valid, state};
    wire [31:0] rd_word = (s_axi_araddr == REG_STRAP) ? strap_word :
                          (s_axi_araddr == REG_STATUS) ? status_word : 32'h00000000;
    wire [STRAP_W-1:0] strap_wr = {w_strb[1] ? w_data[10:8] : strap[10:8],
                                  w_strb[0] ? w_data[7:0] : strap[7:0]};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            strap <= STRAP_RESET;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == REG_STRAP || aw_addr == REG_STATUS) ?
                               RESP_OKAY : RESP_DECERR;
                if (aw_addr == REG_STRAP) begin
                    strap <= strap_wr;
                end
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= ar_map ? RESP_OKAY : RESP_DECERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// *** core/drive_pkg.sv ***
package drive_pkg;

// ==========================================================
// clock and timing
localparam int CLK_MHZ = 10;
localparam int CW = 24;
localparam int T_HEAD_SETTLE_US = 50000;
localparam int T_TRK0_US = 2800;
localparam int T_HOLE_US = 400000;
localparam int T_STEP_SETTLE_US = 18000;
localparam int T_WG_OFF_US = 1000;
localparam int T_SIDE_US = 100;
localparam int T_READY_MAX_US = 800000;
localparam int T_RECAL_US = 255000;
localparam int T_RECAL_STEP_US = 3000;
localparam int T_REV_US = 200000;
localparam int HEAD_SETTLE_CYC = T_HEAD_SETTLE_US * CLK_MHZ;
localparam int TRK0_CYC = T_TRK0_US * CLK_MHZ;
localparam int HOLE_CYC = T_HOLE_US * CLK_MHZ;
localparam int STEP_SETTLE_CYC = T_STEP_SETTLE_US * CLK_MHZ;
localparam int WG_OFF_CYC = T_WG_OFF_US * CLK_MHZ;
localparam int SIDE_CYC = T_SIDE_US * CLK_MHZ;
localparam int READY_MAX_CYC = T_READY_MAX_US * CLK_MHZ;
localparam int RECAL_CYC = T_RECAL_US * CLK_MHZ;
localparam int RECAL_STEP_CYC = T_RECAL_STEP_US * CLK_MHZ;
localparam int REV_CYC = T_REV_US * CLK_MHZ;
localparam int REV_TOL_PCT = 6;
localparam int HALF_SPEED_MUL = 2;

// ==========================================================
// synchroniser bit positions
localparam int NSYNC = 16;
localparam int SI_SEL = 0;
localparam int SI_MOTOR = 4;
localparam int SI_DIR = 5;
localparam int SI_STEP = 6;
localparam int SI_WGATE = 7;
localparam int SI_WDATA = 8;
localparam int SI_SIDE = 9;
localparam int SI_SHARED = 10;
localparam int SI_INDEX = 11;
localparam int SI_DISK = 12;
localparam int SI_PROT = 13;
localparam int SI_ZERO = 14;
localparam int SI_FLUX = 15;
localparam logic [NSYNC-1:0] SYNC_IDLE = 16'h07FF;

// ==========================================================
// register map
localparam logic [3:0] REG_STRAP = 4'h0;
localparam logic [3:0] REG_STATUS = 4'h4;
localparam logic [1:0] RESP_OKAY = 2'h0;
localparam logic [1:0] RESP_DECERR = 2'h3;
localparam int SB_ADDR = 0;
localparam int SB_BUSY = 2;
localparam int SB_LOAD = 3;
localparam int SB_READY = 4;
localparam int SB_OPEN = 5;
localparam int SB_MOTOR = 6;
localparam int SB_RECAL = 7;
localparam int SB_IDXG = 8;
localparam int SB_RDG = 9;
localparam int SB_HARD = 10;
localparam int STRAP_W = 11;
localparam logic [STRAP_W-1:0] STRAP_RESET = 11'h114;

// ==========================================================
// drive states
typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SPIN = 5'h02,
    ST_PRE = 5'h04,
    ST_READY = 5'h08,
    ST_RECAL = 5'h10
} drive_state_t;

endpackage
